// ### core/monitor_converter_control_regs.v
// Control registers, channel scan and input current result of the monitor converter
//
// What this block does
// RQ1: Enable resets to 0; register reset or watchdog expiry clears it.
// RQ2: Results start at zero, keep last measurement, never auto-clear.
// RQ3: Rate bit 0 selects continuous conversion, 1 one-shot; default 0.
// RQ4: Speed field bits 5:4 picks 12/11/10/9-bit resolution; default 3.
// RQ5: Averaging bit 0 reports single values, 1 a running average.
// RQ6: Seed bit 0 starts average from stored value, 1 from fresh sample.
// RQ7: Eight disable bits, reset 0; a set bit skips that channel.
// RQ8: Input current sits in bits 15:1, two's complement, bit 0 zero.
// RQ9: Positive for bus-to-mid-node current, negative for the reverse.
// RQ10: 2 mA per code, clamped between 7830h and 7D0h.
// RQ11: One-shot converts each enabled channel once, then stops.
`timescale 1ns/10ps
module monitor_converter_control_regs (
    // Clock and reset
    input  wire        CLOCK_I,
    input  wire        RSTN_I,
    // Register access from the serial host interface
    input  wire [7:0]  REG_ADDR_I,
    input  wire        REG_WR_I,
    input  wire [7:0]  REG_WDATA_I,
    input  wire        REG_RD_I,
    output wire [7:0]  REG_RDATA_O,
    // Device events
    input  wire        REG_RESET_I,
    input  wire        WATCHDOG_EXPIRED_I,
    // Analog front end
    input  wire        CONV_DONE_I,
    input  wire [15:0] CONV_DATA_I,
    output wire        CONV_START_O,
    output wire [2:0]  CONV_CHANNEL_O,
    output wire [1:0]  CONV_RESOLUTION_O,
    // Settings and results for the other channel registers
    output wire        CONVERTER_ENABLED_O,
    output wire        RUNNING_AVERAGE_O,
    output wire        AVERAGE_SEED_O,
    output wire [7:0]  CHANNEL_OFF_O,
    output wire        RESULT_STROBE_O,
    output wire [2:0]  RESULT_CHANNEL_O,
    output wire [15:0] INPUT_CURRENT_RESULT_O
);
`include "monitor_converter_defines.vh"

    reg         enable_ff;
    reg         nxt_enable;
    reg         one_shot_ff;
    reg  [1:0]  speed_ff;
    reg         running_average_on_ff;
    reg         average_seed_select_ff;
    reg  [7:0]  channel_off_ff;
    reg         enable_d_ff;
    reg         average_d_ff;
    reg  [7:0]  rdata_ff;
    reg  [7:0]  nxt_rdata;
    wire        wr_control;
    wire        wr_disable;
    wire        scan_done;
    wire        sample_take;
    wire [2:0]  channel;
    wire [14:0] input_current_result;
    wire [15:0] result_word;
    wire        restart;

    assign wr_control = REG_WR_I && (REG_ADDR_I == `ADDR_CONVERTER_CONTROL);
    assign wr_disable = REG_WR_I && (REG_ADDR_I == `ADDR_CHANNEL_DISABLE);

    // Enable: a software write wins over a same-cycle watchdog or scan-end clear, but register reset wins over the write
    always @* begin
        nxt_enable = enable_ff;
        if (REG_RESET_I) begin
            nxt_enable = 1'b0;                                     // [RQ1]
        end else if (wr_control) begin
            nxt_enable = REG_WDATA_I[`CTRL_ENABLE_BIT];            // [RQ1]
        end else if (WATCHDOG_EXPIRED_I || scan_done) begin
            nxt_enable = 1'b0;                                     // [RQ1] [RQ11]
        end
    end

    // Control and channel disable registers
    always @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            enable_ff              <= 1'b0;                        // [RQ1]
            one_shot_ff            <= 1'b0;                        // [RQ3]
            speed_ff               <= `SPEED_RESET;                // [RQ4]
            running_average_on_ff  <= 1'b0;                        // [RQ5]
            average_seed_select_ff <= 1'b0;                        // [RQ6]
            channel_off_ff         <= `CHANNEL_DISABLE_RESET;      // [RQ7]
        end else begin
            enable_ff <= nxt_enable;
            if (REG_RESET_I) begin
                one_shot_ff            <= 1'b0;
                speed_ff               <= `SPEED_RESET;
                running_average_on_ff  <= 1'b0;
                average_seed_select_ff <= 1'b0;
                channel_off_ff         <= `CHANNEL_DISABLE_RESET;
            end else begin
                if (wr_control) begin
                    one_shot_ff            <= REG_WDATA_I[`CTRL_RATE_BIT];       // [RQ3]
                    speed_ff               <= REG_WDATA_I[`CTRL_SPEED_MSB:`CTRL_SPEED_LSB];
                    running_average_on_ff  <= REG_WDATA_I[`CTRL_AVERAGE_BIT];
                    average_seed_select_ff <= REG_WDATA_I[`CTRL_SEED_BIT];
                end
                if (wr_disable) begin
                    channel_off_ff <= REG_WDATA_I;                 // [RQ7]
                end
            end
        end
    end

    // Edge history so the average restarts when enable or averaging rises
    always @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            enable_d_ff  <= 1'b0;
            average_d_ff <= 1'b0;
        end else begin
            enable_d_ff  <= enable_ff;
            average_d_ff <= running_average_on_ff;
        end
    end

    assign restart = (enable_ff && !enable_d_ff) || (running_average_on_ff && !average_d_ff);

    // Scan of enabled channels
    conversion_sequencer u_sequencer (
        .clk_i            (CLOCK_I),
        .rstn_i           (RSTN_I),
        .enable_i         (enable_ff),
        .one_shot_i       (one_shot_ff),                           // [RQ3]
        .channel_off_i    (channel_off_ff),
        .conv_done_i      (CONV_DONE_I),
        .conv_start_o     (CONV_START_O),
        .channel_o        (channel),
        .sample_take_o    (sample_take),
        .sample_strobe_o  (RESULT_STROBE_O),
        .sample_channel_o (RESULT_CHANNEL_O),
        .scan_done_o      (scan_done)
    );

    // Only the input current channel feeds this result register
    current_result_filter u_filter (
        .clk_i          (CLOCK_I),
        .rstn_i         (RSTN_I),
        .sample_valid_i (sample_take && (channel == `CH_INPUT_CURRENT)),
        .sample_data_i  (CONV_DATA_I),
        .average_on_i   (running_average_on_ff),
        .seed_fresh_i   (average_seed_select_ff),
        .restart_i      (restart),
        .result_o       (input_current_result)
    );

    assign result_word = {input_current_result, 1'b0};             // [RQ8]

    // Read mux; reserved control bits and unmapped addresses read zero
    always @* begin
        case (REG_ADDR_I)
            `ADDR_CONVERTER_CONTROL: nxt_rdata = {enable_ff, one_shot_ff, speed_ff,
                                                  running_average_on_ff,
                                                  average_seed_select_ff, 2'h0};
            `ADDR_CHANNEL_DISABLE:   nxt_rdata = channel_off_ff;
            `ADDR_RESULT_LOW:        nxt_rdata = result_word[7:0];  // [RQ8]
            `ADDR_RESULT_HIGH:       nxt_rdata = result_word[15:8];
            default:                 nxt_rdata = `UNMAPPED_READ;
        endcase
    end

    // Read data held until the next read
    always @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rdata_ff <= 8'h00;
        end else if (REG_RD_I) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign REG_RDATA_O            = rdata_ff;
    assign CONV_CHANNEL_O         = channel;
    assign CONV_RESOLUTION_O      = speed_ff;                      // [RQ4]
    assign CONVERTER_ENABLED_O    = enable_ff;
    assign RUNNING_AVERAGE_O      = running_average_on_ff;
    assign AVERAGE_SEED_O         = average_seed_select_ff;
    assign CHANNEL_OFF_O          = channel_off_ff;
    assign INPUT_CURRENT_RESULT_O = result_word;
endmodule

// ### core/monitor_converter_defines.vh
// Offsets, field positions, reset values and limits of the converter control block
`ifndef MONITOR_CONVERTER_DEFINES_VH
`define MONITOR_CONVERTER_DEFINES_VH

// Register byte addresses
`define ADDR_CONVERTER_CONTROL    8'h26
`define ADDR_CHANNEL_DISABLE      8'h27
`define ADDR_RESULT_LOW           8'h28
`define ADDR_RESULT_HIGH          8'h29

// Control register field positions
`define CTRL_ENABLE_BIT           7
`define CTRL_RATE_BIT             6
`define CTRL_SPEED_MSB            5
`define CTRL_SPEED_LSB            4
`define CTRL_AVERAGE_BIT          3
`define CTRL_SEED_BIT             2

// Reset values
`define CONTROL_RESET             8'h30
`define CHANNEL_DISABLE_RESET     8'h00
`define SPEED_RESET               2'h3
`define RESULT_RESET              15'h0000
`define UNMAPPED_READ             8'h00

// Channel numbers, equal to their disable bit positions
`define CH_INPUT_CURRENT          3'h7
`define CH_LAST                   3'h7
`define CH_FIRST                  3'h0

// Input current field clamp limits, 2 mA per code
`define INPUT_CURRENT_MAX         15'h07d0
`define INPUT_CURRENT_MIN         15'h7830

`endif

// ### core/conversion_sequencer.v
// Channel scan sequencer for continuous and one-shot conversion
`timescale 1ns/10ps
module conversion_sequencer (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rstn_i,
    // Control
    input  wire        enable_i,
    input  wire        one_shot_i,
    input  wire [7:0]  channel_off_i,
    // Analog front end
    input  wire        conv_done_i,
    output wire        conv_start_o,
    output wire [2:0]  channel_o,
    // Results
    output wire        sample_take_o,
    output wire        sample_strobe_o,
    output wire [2:0]  sample_channel_o,
    output wire        scan_done_o
);
`include "monitor_converter_defines.vh"

    localparam ST_IDLE = 1'b0;
    localparam ST_WAIT = 1'b1;

    reg        state_ff;
    reg        nxt_state;
    reg [2:0]  ch_ff;
    reg [2:0]  nxt_ch;
    reg        start_ff;
    reg        nxt_start;
    reg        strobe_ff;
    reg [2:0]  strobe_ch_ff;
    reg        take;
    reg        scan_done;

    // Next state: walk channels, skipping those switched off
    always @* begin
        nxt_state = state_ff;
        nxt_ch    = ch_ff;
        nxt_start = 1'b0;
        take      = 1'b0;
        scan_done = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (!enable_i) begin
                    nxt_ch = `CH_FIRST;
                end else if (channel_off_i[ch_ff]) begin
                    nxt_ch    = ch_ff + 3'h1;                     // [RQ7]
                    scan_done = one_shot_i && (ch_ff == `CH_LAST); // [RQ11]
                end else begin
                    nxt_start = 1'b1;
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!enable_i) begin
                    // Disabled mid conversion: result dropped, registers untouched
                    nxt_ch    = `CH_FIRST;
                    nxt_state = ST_IDLE;
                end else if (conv_done_i) begin
                    take      = 1'b1;
                    nxt_ch    = ch_ff + 3'h1;
                    scan_done = one_shot_i && (ch_ff == `CH_LAST); // [RQ11]
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_ch    = `CH_FIRST;
            end
        endcase
    end

    // State and output flops
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_ff     <= ST_IDLE;
            ch_ff        <= 3'h0;
            start_ff     <= 1'b0;
            strobe_ff    <= 1'b0;
            strobe_ch_ff <= 3'h0;
        end else begin
            state_ff     <= nxt_state;
            ch_ff        <= nxt_ch;
            start_ff     <= nxt_start;
            strobe_ff    <= take;
            strobe_ch_ff <= take ? ch_ff : strobe_ch_ff;
        end
    end

    // Scan end is combinational so the enable drops before a new start
    assign conv_start_o     = start_ff;
    assign channel_o        = ch_ff;
    assign sample_take_o    = take;
    assign sample_strobe_o  = strobe_ff;
    assign sample_channel_o = strobe_ch_ff;
    assign scan_done_o      = scan_done;
endmodule

// ### core/current_result_filter.v
// Clamp and running average for the signed input current result
`timescale 1ns/10ps
module current_result_filter (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rstn_i,
    // Sample in
    input  wire        sample_valid_i,
    input  wire [15:0] sample_data_i,
    // Averaging control
    input  wire        average_on_i,
    input  wire        seed_fresh_i,
    input  wire        restart_i,
    // Result
    output wire [14:0] result_o
);
`include "monitor_converter_defines.vh"

    reg  [14:0] result_ff;
    reg  [14:0] nxt_result;
    reg         first_ff;
    reg  [14:0] clamped;
    reg  [15:0] sum;

    // Clamp raw code to the field range; sign carried straight through
    always @* begin
        if (!sample_data_i[15] && (sample_data_i > {1'b0, `INPUT_CURRENT_MAX})) begin
            clamped = `INPUT_CURRENT_MAX;                          // [RQ10]
        end else if (sample_data_i[15] && (sample_data_i < {1'b1, `INPUT_CURRENT_MIN})) begin
            clamped = `INPUT_CURRENT_MIN;                          // [RQ10]
        end else begin
            clamped = sample_data_i[14:0];                         // [RQ9]
        end
        sum = {result_ff[14], result_ff} + {clamped[14], clamped};
        nxt_result = result_ff;
        if (sample_valid_i) begin
            if (!average_on_i) begin
                nxt_result = clamped;                              // [RQ5]
            end else if (first_ff && seed_fresh_i) begin
                nxt_result = clamped;                              // [RQ6]
            end else begin
                // Halving the sum keeps the range; older samples decay by half
                nxt_result = sum[15:1];                            // [RQ5] [RQ6]
            end
        end
    end

    // Result is only ever replaced by a finished sample
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            result_ff <= `RESULT_RESET;                            // [RQ2]
            first_ff  <= 1'b1;
        end else begin
            result_ff <= nxt_result;                               // [RQ2]
            if (restart_i || !average_on_i) begin
                first_ff <= 1'b1;
            end else if (sample_valid_i) begin
                first_ff <= 1'b0;
            end
        end
    end

    assign result_o = result_ff;
endmodule

// ### testbench/monitor_converter_checker.sv
// Concurrent checks on the ports of the monitor converter control block
`timescale 1ns/10ps
module monitor_converter_checker (
    // Clock, reset and register access
    input wire        CLOCK_I, RSTN_I, REG_WR_I, REG_RD_I, REG_RESET_I,
    input wire [7:0]  REG_ADDR_I, REG_WDATA_I, REG_RDATA_O,
    // Events and conversion link
    input wire        WATCHDOG_EXPIRED_I, CONV_DONE_I, CONV_START_O,
    input wire        CONVERTER_ENABLED_O, RESULT_STROBE_O,
    input wire [2:0]  CONV_CHANNEL_O, RESULT_CHANNEL_O,
    input wire [1:0]  CONV_RESOLUTION_O,
    input wire [7:0]  CHANNEL_OFF_O,
    input wire [15:0] INPUT_CURRENT_RESULT_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RSTN_I);
    // Control write, excluded where a same-cycle write wins over a clear
    wire ctrl_wr = REG_WR_I && REG_ADDR_I == 8'h26;
    a_start_one_cycle: assert property (CONV_START_O |=> !CONV_START_O)
        else $error("start pulse wider than one cycle");
    a_start_needs_enable: assert property (CONV_START_O |-> $past(CONVERTER_ENABLED_O))
        else $error("start while converter disabled");
    a_start_channel_on: assert property (CONV_START_O |-> !$past(CHANNEL_OFF_O[CONV_CHANNEL_O]))
        else $error("start on a disabled channel");
    a_strobe_follows_done: assert property (RESULT_STROBE_O |-> $past(CONV_DONE_I)
        && RESULT_CHANNEL_O == $past(CONV_CHANNEL_O)) else $error("strobe without done");
    a_result_holds: assert property (!(RESULT_STROBE_O && RESULT_CHANNEL_O == 3'h7)
        |-> $stable(INPUT_CURRENT_RESULT_O)) else $error("result changed without update");
    a_result_in_range: assert property (!INPUT_CURRENT_RESULT_O[0]
        && $signed(INPUT_CURRENT_RESULT_O[15:1]) <= 2000
        && $signed(INPUT_CURRENT_RESULT_O[15:1]) >= -2000) else $error("result out of range");
    a_watchdog_clears: assert property (WATCHDOG_EXPIRED_I && !ctrl_wr |=> !CONVERTER_ENABLED_O)
        else $error("watchdog left converter enabled");
    a_reg_reset_defaults: assert property (REG_RESET_I |=> CONV_RESOLUTION_O == 2'h3
        && !CONVERTER_ENABLED_O && CHANNEL_OFF_O == 8'h00) else $error("register reset missed");
    a_speed_write: assert property (ctrl_wr && !REG_RESET_I
        |=> CONV_RESOLUTION_O == $past(REG_WDATA_I[5:4])) else $error("speed field not written");
    a_unmapped_zero: assert property (REG_RD_I && (REG_ADDR_I < 8'h26 || REG_ADDR_I > 8'h29)
        |=> REG_RDATA_O == 8'h00) else $error("unmapped read not zero");
    // Main scenarios reached
    c_current_result: cover property (RESULT_STROBE_O && RESULT_CHANNEL_O == 3'h7);
    c_watchdog_hit: cover property (WATCHDOG_EXPIRED_I && CONVERTER_ENABLED_O);
    c_reg_reset: cover property (REG_RESET_I);
endmodule

// ### testbench/tb.sv
// Self-checking bench for the converter control block with a reference model
`timescale 1ns/10ps
`include "monitor_converter_defines.vh"
module tb;
    reg         clock_i, rstn_i, wr_i, rd_i, reg_reset_i, wdog_i, done_i;
    reg  [7:0]  addr_i, wdata_i;
    reg  [15:0] data_i, raw, word;
    wire [7:0]  rdata_o, chan_off_o;
    wire [2:0]  chan_o, res_chan_o;
    wire [1:0]  resol_o;
    wire [15:0] result_o;
    wire        start_o, enabled_o, strobe_o, avg_o, seed_o;
    integer     failures, comparisons, exp_field, i, n;
    reg         avg_m, seed_m, first_m;

    monitor_converter_control_regs u_dut (
        .CLOCK_I(clock_i), .RSTN_I(rstn_i), .REG_ADDR_I(addr_i), .REG_WR_I(wr_i),
        .REG_WDATA_I(wdata_i), .REG_RD_I(rd_i), .REG_RDATA_O(rdata_o),
        .REG_RESET_I(reg_reset_i), .WATCHDOG_EXPIRED_I(wdog_i), .CONV_DONE_I(done_i),
        .CONV_DATA_I(data_i), .CONV_START_O(start_o), .CONV_CHANNEL_O(chan_o),
        .CONV_RESOLUTION_O(resol_o), .CONVERTER_ENABLED_O(enabled_o),
        .RUNNING_AVERAGE_O(avg_o), .AVERAGE_SEED_O(seed_o), .CHANNEL_OFF_O(chan_off_o),
        .RESULT_STROBE_O(strobe_o), .RESULT_CHANNEL_O(res_chan_o),
        .INPUT_CURRENT_RESULT_O(result_o));

    // Free-running 200 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    task check(input [8*10-1:0] name, input [15:0] seen, input [15:0] expv);
        begin
            comparisons = comparisons + 1;
            if (seen !== expv) begin
                failures = failures + 1;
                $display("[ERR] %0s expected %h seen %h", name, expv, seen);
            end
        end
    endtask

    task complete_run;
        begin
            $display("comparisons %0d failures %0d", comparisons, failures);
            if (failures == 0 && comparisons > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask

    // Inputs move 1 ns after the edge so no race with the sampling edge
    task step;
        begin
            @(posedge clock_i);
            #1;
        end
    endtask

    task wr_reg(input [7:0] a, input [7:0] d);
        begin
            addr_i = a;
            wdata_i = d;
            wr_i = 1'b1;
            step;
            wr_i = 1'b0;
            step;
        end
    endtask

    task rd_reg(input [7:0] a, input [7:0] expv);
        begin
            addr_i = a;
            rd_i = 1'b1;
            step;
            rd_i = 1'b0;
            check("rdata", rdata_o, expv);
            step;
        end
    endtask

    // Answer one input current conversion and compare against the model
    task convert(input [15:0] r);
        integer c;
        begin
            n = 0;
            while (!start_o && n < 200) begin
                step;
                n = n + 1;
            end
            if (start_o !== 1'b1) begin
                failures = failures + 1;
                complete_run;
            end
            check("start ch", chan_o, 3'h7);
            repeat (1 + $urandom % 3) step;
            done_i = 1'b1;
            data_i = r;
            step;
            done_i = 1'b0;
            data_i = ~r;
            c = $signed(r);
            c = (c > 2000) ? 2000 : ((c < -2000) ? -2000 : c);
            if (!avg_m || (first_m && seed_m)) exp_field = c;
            else exp_field = (exp_field + c) >>> 1;
            first_m = 1'b0;
            check("strobe", {12'h000, strobe_o, res_chan_o}, 16'h000f);
            check("result", result_o, 16'(exp_field * 2));
        end
    endtask

    initial begin
        {rstn_i, wr_i, rd_i, reg_reset_i, wdog_i, done_i} = 6'h00;
        {addr_i, wdata_i, data_i} = 32'h0;
        {failures, comparisons, exp_field} = 96'h0;
        {avg_m, seed_m, first_m} = 3'h0;
        n = $urandom(30);
        repeat (8) @(posedge clock_i);
        #1 rstn_i = 1'b1;
        step;
        check("resolution", resol_o, 2'h3);
        rd_reg(`ADDR_CONVERTER_CONTROL, 8'h30);
        rd_reg(`ADDR_CHANNEL_DISABLE, 8'h00);
        rd_reg(`ADDR_RESULT_LOW, 8'h00);
        rd_reg(`ADDR_RESULT_HIGH, 8'h00);
        rd_reg(8'h50, 8'h00);
        $display("test reset values done");
        for (i = 0; i < 4; i = i + 1) begin
            wr_reg(`ADDR_CONVERTER_CONTROL, {2'b00, i[1:0], 4'hf});
            rd_reg(`ADDR_CONVERTER_CONTROL, {2'b00, i[1:0], 4'hc});
            check("resolution", resol_o, i[1:0]);
        end
        raw = $urandom;
        wr_reg(`ADDR_CHANNEL_DISABLE, raw[7:0]);
        rd_reg(`ADDR_CHANNEL_DISABLE, raw[7:0]);
        check("chan off", chan_off_o, raw[7:0]);
        wr_reg(`ADDR_RESULT_LOW, 8'hff);
        rd_reg(`ADDR_RESULT_LOW, 8'h00);
        $display("test register access done");
        // Only the input current channel converts, the rest are skipped
        wr_reg(`ADDR_CHANNEL_DISABLE, 8'h7f);
        wr_reg(`ADDR_CONVERTER_CONTROL, 8'h80);
        for (i = 0; i < 12; i = i + 1) begin
            raw = $urandom;
            case (i)
                0: raw = 16'h07d0;
                1: raw = 16'h07d1;
                2: raw = 16'hf830;
                3: raw = 16'hf82f;
                4: raw = 16'h7fff;
                5: raw = 16'h8000;
            endcase
            convert(raw);
        end
        check("enabled", enabled_o, 1'b1);
        wdog_i = 1'b1;
        step;
        wdog_i = 1'b0;
        check("enabled", enabled_o, 1'b0);
        // Every field set, so the register reset has something to clear
        wr_reg(`ADDR_CONVERTER_CONTROL, 8'hff);
        check("enabled", enabled_o, 1'b1);
        reg_reset_i = 1'b1;
        step;
        reg_reset_i = 1'b0;
        rd_reg(`ADDR_CONVERTER_CONTROL, 8'h30);
        rd_reg(`ADDR_CHANNEL_DISABLE, 8'h00);
        word = 16'(exp_field * 2);
        rd_reg(`ADDR_RESULT_LOW, word[7:0]);
        rd_reg(`ADDR_RESULT_HIGH, word[15:8]);
        $display("test continuous conversion done");
        // One-shot: one scan, then the enable drops and no more starts
        wr_reg(`ADDR_CHANNEL_DISABLE, 8'h7f);
        wr_reg(`ADDR_CONVERTER_CONTROL, 8'hc0);
        raw = $urandom;
        convert(raw);
        check("enabled", enabled_o, 1'b0);
        n = 0;
        repeat (40) begin
            step;
            n = n + start_o;
        end
        check("starts", n[15:0], 16'h0000);
        $display("test one shot done");
        // Running average, seeded fresh then from the stored value
        avg_m = 1'b1;
        for (i = 0; i < 2; i = i + 1) begin
            seed_m = ~i[0];
            first_m = 1'b1;
            wr_reg(`ADDR_CONVERTER_CONTROL, 8'h00);
            wr_reg(`ADDR_CONVERTER_CONTROL, {4'h8, 1'b1, seed_m, 2'b00});
            check("avg seed", {14'h0, avg_o, seed_o}, {14'h0, avg_m, seed_m});
            repeat (4) begin
                raw = 16'(($urandom % 4001) - 2000);
                convert(raw);
            end
        end
        $display("test running average done");
        complete_run;
    end
endmodule

bind monitor_converter_control_regs monitor_converter_checker u_chk (
    .CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_RESET_I(REG_RESET_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
    .REG_RDATA_O(REG_RDATA_O), .WATCHDOG_EXPIRED_I(WATCHDOG_EXPIRED_I),
    .CONV_DONE_I(CONV_DONE_I), .CONV_START_O(CONV_START_O),
    .CONVERTER_ENABLED_O(CONVERTER_ENABLED_O), .RESULT_STROBE_O(RESULT_STROBE_O),
    .CONV_CHANNEL_O(CONV_CHANNEL_O), .RESULT_CHANNEL_O(RESULT_CHANNEL_O),
    .CONV_RESOLUTION_O(CONV_RESOLUTION_O), .CHANNEL_OFF_O(CHANNEL_OFF_O),
    .INPUT_CURRENT_RESULT_O(INPUT_CURRENT_RESULT_O));
